/* File: common/dsc_map.vh */
/*
 * constants for the drive state command decoder: control and status word
 * bit positions, readiness codes, reset values.
 * assumes a 16-bit cyclic control/status word exchange.
 */
`ifndef DSC_MAP_VH
`define DSC_MAP_VH

// ****************************************
// control word fields
// ****************************************
`define DSC_CW_START 4'hf
`define DSC_CW_ENABLE 4'he
`define DSC_CW_HALT 4'hd
`define DSC_CW_MODE 4'ha

// ****************************************
// status word fields
// ****************************************
`define DSC_SW_RDY_HI 4'hf
`define DSC_SW_RDY_LO 4'he
`define DSC_SW_ERR 4'hd
`define DSC_SW_WARN 4'hc
`define DSC_SW_MODE 4'ha
`define DSC_SW_QSTOP 4'h7
`define DSC_SW_POSFB 4'h5
`define DSC_SW_HALT 4'h4
`define DSC_SW_CMDV 4'h3

// ****************************************
// readiness codes and reset values
// ****************************************
`define DSC_RDY_NOTRDY 2'h0
`define DSC_RDY_DISABLED 2'h1
`define DSC_RDY_SWON 2'h2
`define DSC_RDY_ENABLED 2'h3
`define DSC_CW_RESET 16'h0000
`define DSC_SW_RESET 16'h0000
// status in state 3: power stage supply absent / present
`define DSC_SW_RDY_NOPWR 16'h0021
`define DSC_SW_RDY_PWR 16'h0031
// cycles spent in the transient start-up state
`define DSC_INIT_CYCLES 8'h10

`endif

/* File: hw/dsc_decoder.v */
/*
 * drive state command decoder: turns each cyclic control word into
 * operating-state transitions and builds the cyclic status word.
 * assumes cw_valid pulses once per fieldbus cycle with a fresh word,
 * and that fault, warning and supply inputs are synchronous to clk_sys.
 */
`timescale 1ns/1ns
`include "dsc_map.vh"

// Summary of operation
// - rising start edge with enable set starts following commands; falling stops.
// - enable bit rising enables the drive, falling disables it.
// - halt bit acts only with start and enable set; fall halts, rise restarts.
// - mode bit 10 zero means primary mode; bits 9 and 8 kept zero.
// - enable low shuts states 4,5a,5b,6 to 3; enable rise moves 3 to 4.
// - in state 4, start rise with enable enters 5a, or 5b if halt set.
// - halt edges swap 5a and 5b; start fall with enable enters quick stop.
// - fault state leaves for switch-on-disabled only on fault reset.
// - power stage disable request moves 4,5a,5b,6 to switch-on-disabled.
// - status bits 15-14 give the readiness code.
// - status bit 13 shows shut-down error, bit 12 shows warning.
// - bit 5 shows position feedback status, bit 3 command processing.
// - bit 7 shows quick stop active, bit 4 shows halt active.
// - readiness code 00,01,10,11 for states 1,2,3,4.
// - 5a reports the processing bit, 5b the halt bit, 6 the quick stop and halt bits as set.
// - fault reaction reads 11, fault reads 10, both with error bit set.
// - during halt stay operation enabled with no motor power or torque.
// - ready-to-switch-on reads 21 hex without supply, 31 hex with it.
module dsc_decoder #(
    parameter INIT_CYCLES = `DSC_INIT_CYCLES
) (
    input wire clk_sys,
    input wire resetn,
    input wire [15:0] cw_data,
    input wire cw_valid,
    input wire init_done,
    input wire fault_detect,
    input wire fault_reaction_done,
    input wire fault_reset,
    input wire power_disable_req,
    input wire supply_present,
    input wire warning,
    input wire posfb_status,
    output reg [15:0] drive_state_word,
    output reg [15:0] drive_command_word,
    output reg follow_cmd,
    output reg motor_power,
    output reg [8:0] op_state
);

// ****************************************
// states (one-hot)
// ****************************************
localparam S1 = 9'h001;
localparam S2 = 9'h002;
localparam S3 = 9'h004;
localparam S4 = 9'h008;
localparam S5A = 9'h010;
localparam S5B = 9'h020;
localparam S6 = 9'h040;
localparam S7 = 9'h080;
localparam S8 = 9'h100;

// ****************************************
// reset release
// ****************************************
reg rst_s1_r;
reg rst_s2_r;
wire rstn_int;

always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
        rst_s1_r <= 1'b0;
        rst_s2_r <= 1'b0;
    end else begin
        rst_s1_r <= 1'b1;
        rst_s2_r <= rst_s1_r;
    end
end
assign rstn_int = rst_s2_r;

// ****************************************
// edge detection
// ****************************************
function rise;
    input [15:0] prev;
    input [15:0] cur;
    input [3:0] bit_pos;
    begin
        rise = ~prev[bit_pos] & cur[bit_pos];
    end
endfunction

function fall;
    input [15:0] prev;
    input [15:0] cur;
    input [3:0] bit_pos;
    begin
        fall = prev[bit_pos] & ~cur[bit_pos];
    end
endfunction

// previous word held in drive_command_word; edges only on a fresh word
wire [15:0] prev = drive_command_word;
wire start_rise = cw_valid & rise(prev, cw_data, `DSC_CW_START);
wire start_fall = cw_valid & fall(prev, cw_data, `DSC_CW_START);
wire en_rise = cw_valid & rise(prev, cw_data, `DSC_CW_ENABLE);
wire halt_rise = cw_valid & rise(prev, cw_data, `DSC_CW_HALT);
wire halt_fall = cw_valid & fall(prev, cw_data, `DSC_CW_HALT);
wire en_now = cw_data[`DSC_CW_ENABLE];
wire start_now = cw_data[`DSC_CW_START];
wire halt_now = cw_data[`DSC_CW_HALT];

// ****************************************
// init timer for the transient state 1
// ****************************************
localparam CW = 8;
reg [CW-1:0] init_cnt_r;
wire init_over = (init_cnt_r == INIT_CYCLES[CW-1:0]) | init_done;

always @(posedge clk_sys or negedge rstn_int) begin
    if (!rstn_int)
        init_cnt_r <= {CW{1'b0}};
    else if (!init_over)
        init_cnt_r <= init_cnt_r + {{(CW-1){1'b0}}, 1'b1};
end

// ****************************************
// shared decoding helpers
// ****************************************
// membership of a one-hot state in a set of states
function in_set;
    input [8:0] st;
    input [8:0] set_mask;
    begin
        in_set = |(st & set_mask);
    end
endfunction

// readiness code shown in the top two status bits
function [1:0] rdy_code;
    input [8:0] st;
    begin
        case (st)
        S1: rdy_code = `DSC_RDY_NOTRDY;
        S2: rdy_code = `DSC_RDY_DISABLED;
        S3: rdy_code = `DSC_RDY_SWON;
        S4, S5A, S5B, S6, S7: rdy_code = `DSC_RDY_ENABLED;
        S8: rdy_code = `DSC_RDY_SWON;
        default: rdy_code = `DSC_RDY_NOTRDY;
        endcase
    end
endfunction

// ****************************************
// transition commands
// ****************************************
// one wire per row of the transition table; the state machine only
// decides which of them may act in the present state
wire run_bits_set;
wire cmd_shutdown;
wire cmd_switch_on;
wire cmd_enable_op;
wire cmd_enable_halted;
wire cmd_halt;
wire cmd_run;
wire cmd_quick_stop;
wire fault_take;

assign run_bits_set = start_now & en_now;
// enable low wins over whatever start and halt are doing
assign cmd_shutdown = cw_valid & ~en_now;
assign cmd_switch_on = en_rise;
assign cmd_enable_op = start_rise & en_now & ~halt_now;
assign cmd_enable_halted = start_rise & en_now & halt_now;
assign cmd_halt = halt_fall & run_bits_set;
assign cmd_run = halt_rise & run_bits_set;
assign cmd_quick_stop = start_fall & en_now;
// faults are not taken before initialisation ends or while handled
assign fault_take = fault_detect & ~in_set(op_state, S1 | S7 | S8);

// ****************************************
// operating state machine
// ****************************************
reg [8:0] state_nxt;

// priority: fault, power stage disable, shutdown, then control edges
always @* begin
    state_nxt = op_state;
    case (op_state)
    S1: begin
        // transient start-up state, invisible to the master
        if (init_over) begin
            state_nxt = S2;
        end
    end
    S2: begin
        // leave switch-on-disabled once the master shuts down (enable low)
        if (cmd_shutdown) begin
            state_nxt = S3;
        end
    end
    S3: begin
        if (cmd_switch_on) begin
            state_nxt = S4;
        end
    end
    S4: begin
        if (power_disable_req) begin
            state_nxt = S2;
        end else if (cmd_shutdown) begin
            state_nxt = S3;
        end else if (cmd_enable_op) begin
            state_nxt = S5A;
        end else if (cmd_enable_halted) begin
            state_nxt = S5B;
        end
    end
    S5A: begin
        if (power_disable_req) begin
            state_nxt = S2;
        end else if (cmd_shutdown) begin
            state_nxt = S3;
        end else if (cmd_quick_stop) begin
            state_nxt = S6;
        end else if (cmd_halt) begin
            state_nxt = S5B;
        end
    end
    S5B: begin
        // halted but still operation enabled; flags, follow_cmd and motor_power differ
        if (power_disable_req) begin
            state_nxt = S2;
        end else if (cmd_shutdown) begin
            state_nxt = S3;
        end else if (cmd_quick_stop) begin
            state_nxt = S6;
        end else if (cmd_run) begin
            state_nxt = S5A;
        end
    end
    S6: begin
        if (power_disable_req) begin
            state_nxt = S2;
        end else if (cmd_shutdown) begin
            state_nxt = S3;
        end
    end
    S7: begin
        // the error response runs elsewhere; wait for it to finish
        if (fault_reaction_done) begin
            state_nxt = S8;
        end
    end
    S8: begin
        // control words are ignored; only a fault reset leaves
        if (fault_reset) begin
            state_nxt = S2;
        end
    end
    default: begin
        // an illegal code restarts the power-up sequence
        state_nxt = S1;
    end
    endcase
    if (fault_take) begin
        state_nxt = S7;
    end
end

// ****************************************
// status word assembly
// ****************************************
reg [15:0] sw_nxt;
reg [15:0] rdy_pat;
reg [1:0] rdy;

// built from the next state so status and state change on one edge
always @* begin
    sw_nxt = `DSC_SW_RESET; // mode bit 10 and bits 9, 8 read 0
    rdy = rdy_code(state_nxt);
    rdy_pat = `DSC_SW_RDY_NOPWR;
    if (supply_present) begin
        rdy_pat = `DSC_SW_RDY_PWR;
    end
    sw_nxt[`DSC_SW_RDY_HI] = rdy[1];
    sw_nxt[`DSC_SW_RDY_LO] = rdy[0];
    sw_nxt[`DSC_SW_ERR] = in_set(state_nxt, S7 | S8);
    sw_nxt[`DSC_SW_WARN] = warning;
    sw_nxt[`DSC_SW_QSTOP] = in_set(state_nxt, S6);
    sw_nxt[`DSC_SW_HALT] = in_set(state_nxt, S5B | S6);
    sw_nxt[`DSC_SW_CMDV] = in_set(state_nxt, S5A);
    sw_nxt[`DSC_SW_POSFB] = posfb_status;
    // the supply pattern goes last: the halt and feedback bits above
    // would otherwise spoil the fixed low byte of ready-to-switch-on
    if (in_set(state_nxt, S3)) begin
        sw_nxt[7:0] = rdy_pat[7:0];
    end
end

// ****************************************
// state and command word registers
// ****************************************
// one-hot code, exactly one bit set at any time
always @(posedge clk_sys or negedge rstn_int) begin
    if (!rstn_int) begin
        op_state <= S1;
    end else begin
        op_state <= state_nxt;
    end
end

// the last accepted word is the reference for the next edge search
always @(posedge clk_sys or negedge rstn_int) begin
    if (!rstn_int) begin
        drive_command_word <= `DSC_CW_RESET;
    end else if (cw_valid) begin
        drive_command_word <= cw_data;
    end
end

// ****************************************
// status word and drive outputs
// ****************************************
always @(posedge clk_sys or negedge rstn_int) begin
    if (!rstn_int) begin
        drive_state_word <= `DSC_SW_RESET;
    end else begin
        drive_state_word <= sw_nxt;
    end
end

always @(posedge clk_sys or negedge rstn_int) begin
    if (!rstn_int) begin
        follow_cmd <= 1'b0;
        motor_power <= 1'b0;
    end else begin
        follow_cmd <= in_set(state_nxt, S5A);
        // halt keeps state 5 but removes motor power and torque; quick
        // stop keeps power so the drive can brake
        motor_power <= in_set(state_nxt, S5A | S6);
    end
end

endmodule // dsc_decoder

/* File: sim/dsc_master.sv */
/* fieldbus master model: sends one control word per request.
   assumes requests change at the falling edge of clk_sys. */
`timescale 1ns/1ns
module dsc_master (
    input wire clk_sys,
    input wire [15:0] w,
    input wire go,
    output logic [15:0] cw_data = 16'h0000,
    output logic cw_valid = 1'b0
);
    always @(negedge clk_sys) begin
        cw_valid <= go;
        // idle bus toggles so stale words never look valid
        cw_data <= go ? (w & 16'he000) : ~cw_data;
    end
endmodule // dsc_master

/* File: sim/dsc_decoder_monitor.sv */
/* checker on the decoder ports.
   assumes status and state update on the same edge. */
`timescale 1ns/1ns
module dsc_decoder_monitor (
    input wire clk_sys,
    input wire resetn,
    input wire [15:0] cw_data,
    input wire cw_valid,
    input wire fault_detect,
    input wire fault_reset,
    input wire power_disable_req,
    input wire supply_present,
    input wire [15:0] drive_state_word,
    input wire follow_cmd,
    input wire [8:0] op_state
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    wire [15:0] sw = drive_state_word;
    sequence s_shut;
        cw_valid && !cw_data[14] && |op_state[6:3];
    endsequence
    sequence s_calm;
        !fault_detect && !power_disable_req;
    endsequence
    property p_shut; s_shut ##0 s_calm |=> op_state[2]; endproperty
    property p_on; |op_state[7:3] |-> sw[15:14] == 2'h3; endproperty
    property p_off; op_state[1] |-> sw[15:14] == 2'h1; endproperty
    property p_rdy;
        op_state[2] |-> sw[11:0] ==
            ($past(supply_present) ? 12'h031 : 12'h021);
    endproperty
    property p_run; op_state[4] |-> sw[4:3] == 2'h1 && follow_cmd;
    endproperty
    property p_qs; op_state[6] |-> sw[7] && sw[4:3] == 2'h2; endproperty
    property p_flt;
        op_state[8] |-> sw[15:13] == 3'h5 && sw[4:3] == 2'h0;
    endproperty
    property p_stay; op_state[8] && !fault_reset |=> op_state[8];
    endproperty
    property p_mode; sw[10:8] == 3'h0; endproperty
    a_shut: assert property (p_shut) else $error("no shutdown");
    a_on: assert property (p_on) else $error("bad code");
    a_off: assert property (p_off) else $error("bad code 2");
    a_rdy: assert property (p_rdy) else $error("bad ready");
    a_run: assert property (p_run) else $error("bad run");
    a_qs: assert property (p_qs) else $error("bad qstop");
    a_flt: assert property (p_flt) else $error("bad fault");
    a_stay: assert property (p_stay) else $error("left fault");
    a_mode: assert property (p_mode) else $error("bad mode");
endmodule // dsc_decoder_monitor
bind dsc_decoder dsc_decoder_monitor u_mon (.clk_sys(clk_sys),
    .resetn(resetn), .cw_data(cw_data), .cw_valid(cw_valid),
    .fault_detect(fault_detect), .fault_reset(fault_reset),
    .power_disable_req(power_disable_req),
    .supply_present(supply_present), .follow_cmd(follow_cmd),
    .drive_state_word(drive_state_word), .op_state(op_state));

/* File: sim/drive_state_command_decoder_tb.sv */
/* bench: control words through the master model, events pulsed.
   assumes decoder, master model and checker compiled first. */
`timescale 1ns/1ns
module drive_state_command_decoder_tb;
    logic clk_sys = 0, resetn = 0, go = 0, supply_present = 0;
    logic warning = 0, posfb = 0;
    logic [15:0] w = 16'h0000;
    logic [3:0] ev = 4'h0;
    wire [15:0] cw_data, sw, dcw;
    wire cw_valid, follow_cmd, motor_power;
    wire [8:0] op_state;
    int fail_count = 0, n_tests = 0, cyc = 0;
    logic [15:0] tw [9] = '{16'h4000, 16'hc000, 16'he000, 16'hc000,
        16'he000, 16'h4000, 16'h0000, 16'h4000, 16'he000};
    logic [15:0] te [9] = '{16'hc000, 16'hc008, 16'hc008, 16'hc010,
        16'hc008, 16'hc090, 16'h8031, 16'hc000, 16'hc010};
    logic [1:0] tp [9] = '{2'h0, 2'h3, 2'h3, 2'h0, 2'h3, 2'h1, 2'h0,
        2'h0, 2'h0};
    always #5 clk_sys = ~clk_sys;
    dsc_master u_mst (.clk_sys(clk_sys), .w(w), .go(go),
        .cw_data(cw_data), .cw_valid(cw_valid));
    dsc_decoder #(.INIT_CYCLES(4)) u_dut (.clk_sys(clk_sys),
        .resetn(resetn), .cw_data(cw_data), .cw_valid(cw_valid),
        .init_done(1'b0), .fault_detect(ev[1]),
        .fault_reaction_done(ev[2]), .fault_reset(ev[3]),
        .power_disable_req(ev[0]), .supply_present(supply_present),
        .warning(warning), .posfb_status(posfb),
        .drive_state_word(sw), .drive_command_word(dcw),
        .follow_cmd(follow_cmd), .motor_power(motor_power),
        .op_state(op_state));
    task chk(input [15:0] got, input [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected t=%0t got %h want %h", $time, got, exp);
        end
    endtask
    task send(input [15:0] v);
        @(negedge clk_sys);
        go <= 1'b1;
        w <= v;
        @(negedge clk_sys);
        go <= 1'b0;
        repeat (3) @(negedge clk_sys);
    endtask
    task pulse(input [3:0] e);
        @(negedge clk_sys);
        ev = e;
        @(negedge clk_sys);
        ev = 4'h0;
        repeat (2) @(negedge clk_sys);
    endtask
    task final_report;
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // ****************************************
    // cut a hang short
    // ****************************************
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 3000) begin
            fail_count++;
            final_report();
        end
    end
    initial begin
        repeat (8) @(negedge clk_sys);
        resetn = 1;
        repeat (12) @(negedge clk_sys);
        chk(sw, 16'h4000);
        warning = 1;
        posfb = 1;
        repeat (2) @(negedge clk_sys);
        chk(sw, 16'h5020);
        warning = 0;
        posfb = 0;
        send(16'h0000);
        chk(sw, 16'h8021);
        supply_present = 1;
        send(16'h0000);
        chk(sw, 16'h8031);
        for (int i = 0; i < 9; i++) begin
            send(tw[i]);
            chk(sw, te[i]);
            chk(dcw, tw[i]);
            chk({14'h0, follow_cmd, motor_power}, {14'h0, tp[i]});
        end
        pulse(4'h1);
        chk(sw, 16'h4000);
        pulse(4'h2);
        chk(sw, 16'he000);
        pulse(4'h4);
        chk(sw, 16'ha000);
        send(16'hc000);
        chk(sw, 16'ha000);
        pulse(4'h8);
        chk(sw, 16'h4000);
        final_report();
    end
endmodule // drive_state_command_decoder_tb
